/* htc_comp_clamp.sv */
// Purpose: Temperature compensation and output clamping of converter samples
// Assumes: Ambient temperature arrives as signed whole degrees on the same clock
// Notes:   One sample per accepted handshake; result leaves through a two-entry buffer
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "htc_defs.svh"

// How it works
// [R1] Upper limit spans 51 to 100 percent of full scale.
// [R2] Lower limit spans 0 to 49 percent of full scale.
// [R3] One limit code step moves the limit about 0.0239 percent.
// [R4] Offset drift coefficient adds a first-order term cancelling offset drift.
// [R5] Sensitivity correction has a hot segment above and cold below 25 C.
// [R6] Each segment owns independent linear and quadratic coefficients.
// [R7] Segment coefficients are picked from the present ambient temperature.
// [R8] Output is sample plus sample times gain polynomial plus offset term.
// [R9] Temperature delta is ambient minus 25 C, signed.
// [R10] Samples enter from the converter through a valid/ready port.
// [R11] Offset coefficient in gauss scales to output by the initial gain.
// [R12] Linear coefficients are eight bits each.
// [R13] Quadratic coefficients are nine bits each.
// [R14] After reset lower limit is 0 and upper limit 100 percent.
// [R15] Diagnostic levels bypass the clamps.
// [R16] Results saturate between lower and upper limits, else pass unchanged.
// [R17] At exactly 25 C the cold set is used.
module htc_comp_clamp
  import htc_pkg::*;
#(
  parameter int INITIAL_GAIN = 16'h0015,
  parameter int OFFSET_SHIFT = 8
) (
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic        [7:0] reg_addr_in,
  input  wire logic       [31:0] reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic            [31:0] reg_rdata_out,
  input  wire logic signed [8:0] ambient_temp_in,
  input  wire logic              converter_valid_in,
  output logic                   converter_ready_out,
  input  wire logic       [15:0] converter_sample_in,
  output logic                   compensated_valid_out,
  input  wire logic              compensated_ready_in,
  output htc_result_type         compensated_sample_out
);

  if (INITIAL_GAIN < 1 || INITIAL_GAIN > 65535 || OFFSET_SHIFT < 0 || OFFSET_SHIFT > 30)
  begin : g_bad_param
    $error("INITIAL_GAIN or OFFSET_SHIFT out of range");
  end

  // Worst-case gain times a full-scale sample fits well inside 48 bits
  localparam logic signed [47:0] GAIN_S = 48'(INITIAL_GAIN);


  htc_coef_set_type  coef_hot;
  htc_coef_set_type  coef_cold;
  logic        [7:0] offset_drift_coef;
  logic       [10:0] upper_code;
  logic       [10:0] lower_code;
  logic              diag_mode;
  logic       [15:0] diag_level;
  logic       [15:0] last_out;
  logic        [2:0] status;
  htc_coef_set_type  next_coef_hot;
  htc_coef_set_type  next_coef_cold;
  logic        [7:0] next_offset_drift_coef;
  logic       [10:0] next_upper_code;
  logic       [10:0] next_lower_code;
  logic              next_diag_mode;
  logic       [15:0] next_diag_level;
  logic       [15:0] next_last_out;
  logic        [2:0] next_status;
  logic       [31:0] next_rdata;

  logic signed  [9:0] delta;
  logic               hot;
  htc_coef_set_type   coef;
  logic signed  [8:0] lin;
  logic signed [47:0] gain;
  logic signed [47:0] sample_s;
  logic signed [47:0] corr;
  logic signed [47:0] offset_term;
  logic signed [47:0] total;
  logic        [15:0] upper_limit;
  logic        [15:0] lower_limit;
  logic        [15:0] clamped;
  logic               hit_high;
  logic               hit_low;
  htc_result_type     result;
  logic               push;

  // [R1] Upper limit
  // [R3] Code step scale
  // [R14] Top code is full scale
  always_comb begin
    upper_limit = `HTC_CLP_HIGH_BASE
                  + 16'((32'(upper_code) * `HTC_CLP_STEP_Q8) >> `HTC_CLP_FRAC_SHIFT);
    if (upper_code == `HTC_CLP_CODE_MAX) begin
      upper_limit = `HTC_FULL_SCALE;
    end
    // [R2] Lower limit
    lower_limit = 16'((32'(lower_code) * `HTC_CLP_STEP_Q8) >> `HTC_CLP_FRAC_SHIFT);
  end

  always_comb begin
    // [R9] Delta from 25 C
    delta = 10'($signed({ambient_temp_in[8], ambient_temp_in}) - `HTC_REF_TEMP_C);
    // [R17] Zero delta uses cold set
    hot = (delta > 10'sd0);
    // [R5] Segment choice
    // [R7] Pick by temperature
    coef = hot ? coef_hot : coef_cold;
    // [R12] Linear code is biased
    lin = $signed({1'b0, coef.lin}) - `HTC_LIN_BIAS;
    // [R8] Gain polynomial
    gain = ((48'(lin) * 48'(delta)) <<< `HTC_LIN_SHIFT)
           + 48'($signed(coef.quad)) * 48'(delta) * 48'(delta);
    // [R10] Converter sample
    sample_s = 48'($signed({1'b0, converter_sample_in}));

    // Arithmetic shift keeps a negative correction negative
    corr = (gain * sample_s) >>> `HTC_GAIN_SHIFT;
    // [R4] Offset drift term
    // [R11] Gauss to output units
    offset_term = (48'($signed(offset_drift_coef)) * 48'(delta) * GAIN_S) >>> OFFSET_SHIFT;

    // Sum stays wide so an overshoot is clamped, never wrapped
    total = sample_s + corr + offset_term;

    // [R16] Saturate to limits
    hit_high = (total > 48'($signed({1'b0, upper_limit})));
    hit_low  = (total < 48'($signed({1'b0, lower_limit})));
    clamped  = total[15:0];
    if (hit_high) begin
      clamped = upper_limit;
    end else if (hit_low) begin
      clamped = lower_limit;
    end

    // [R15] Diagnostic bypass
    result.diag  = diag_mode;
    result.value = diag_mode ? diag_level : clamped;
  end

  // Ready is the buffer's registered ready, so a stalled receiver loses nothing
  assign push = converter_valid_in && converter_ready_out;
  // Status and last output follow the accept, not the receiver's take

  htc_pair_buffer #(
    .WIDTH($bits(htc_result_type))
  ) u_out_buffer (
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (converter_valid_in),
    .in_ready_out  (converter_ready_out),
    .in_data_in    (result),
    .out_valid_out (compensated_valid_out),
    .out_ready_in  (compensated_ready_in),
    .out_data_out  (compensated_sample_out)
  );

  always_comb begin
    next_coef_hot          = coef_hot;
    next_coef_cold         = coef_cold;
    next_offset_drift_coef = offset_drift_coef;
    next_upper_code        = upper_code;
    next_lower_code        = lower_code;
    next_diag_mode         = diag_mode;
    next_diag_level        = diag_level;
    next_last_out          = last_out;
    next_status            = status;
    next_rdata             = 32'h00000000;

    // Status is live per sample, so no set and clear race exists
    if (push) begin
      next_last_out = result.value;
      next_status[`HTC_STAT_HIGH_BIT] = hit_high && !diag_mode;
      next_status[`HTC_STAT_LOW_BIT]  = hit_low && !diag_mode;
      next_status[`HTC_STAT_HOT_BIT]  = hot;
    end
    // [R6] Independent coefficient writes
    // [R13] Nine-bit quadratic fields
    if (reg_write_in) begin
      case (reg_addr_in)
        `HTC_ADDR_LIN_HOT:     next_coef_hot.lin      = reg_wdata_in[7:0];
        `HTC_ADDR_LIN_COLD:    next_coef_cold.lin     = reg_wdata_in[7:0];
        `HTC_ADDR_QUAD_HOT:    next_coef_hot.quad     = reg_wdata_in[8:0];
        `HTC_ADDR_QUAD_COLD:   next_coef_cold.quad    = reg_wdata_in[8:0];
        `HTC_ADDR_OFFSET_COEF: next_offset_drift_coef = reg_wdata_in[7:0];
        `HTC_ADDR_UPPER:       next_upper_code        = reg_wdata_in[10:0];
        `HTC_ADDR_LOWER:       next_lower_code        = reg_wdata_in[10:0];
        `HTC_ADDR_CONTROL:     next_diag_mode         = reg_wdata_in[`HTC_CTRL_DIAG_BIT];
        `HTC_ADDR_DIAG_LEVEL:  next_diag_level        = reg_wdata_in[15:0];
        default:               next_diag_level        = diag_level;
      endcase
    end

    // Unmapped addresses read as zero
    if (reg_read_in) begin
      case (reg_addr_in)
        `HTC_ADDR_LIN_HOT:     next_rdata = {24'h000000, coef_hot.lin};
        `HTC_ADDR_LIN_COLD:    next_rdata = {24'h000000, coef_cold.lin};
        `HTC_ADDR_QUAD_HOT:    next_rdata = {23'h000000, coef_hot.quad};
        `HTC_ADDR_QUAD_COLD:   next_rdata = {23'h000000, coef_cold.quad};
        `HTC_ADDR_OFFSET_COEF: next_rdata = {24'h000000, offset_drift_coef};
        `HTC_ADDR_UPPER:       next_rdata = {21'h000000, upper_code};
        `HTC_ADDR_LOWER:       next_rdata = {21'h000000, lower_code};
        `HTC_ADDR_CONTROL:     next_rdata = {31'h00000000, diag_mode};
        `HTC_ADDR_DIAG_LEVEL:  next_rdata = {16'h0000, diag_level};
        `HTC_ADDR_LAST_OUT:    next_rdata = {16'h0000, last_out};
        `HTC_ADDR_STATUS:      next_rdata = {29'h00000000, status};
        default:               next_rdata = 32'h00000000;
      endcase
    end
  end

  // [R14] Reset clamp codes
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      coef_hot          <= '{lin: `HTC_RST_LIN, quad: `HTC_RST_QUAD};
      coef_cold         <= '{lin: `HTC_RST_LIN, quad: `HTC_RST_QUAD};
      offset_drift_coef <= `HTC_RST_OFFSET;
      upper_code        <= `HTC_RST_UPPER;
      lower_code        <= `HTC_RST_LOWER;
      diag_mode         <= 1'b0;
      diag_level        <= `HTC_RST_DIAG_LEVEL;
      last_out          <= 16'h0000;
      status            <= 3'h0;
      reg_rdata_out     <= 32'h00000000;
    end else begin
      coef_hot          <= next_coef_hot;
      coef_cold         <= next_coef_cold;
      offset_drift_coef <= next_offset_drift_coef;
      upper_code        <= next_upper_code;
      lower_code        <= next_lower_code;
      diag_mode         <= next_diag_mode;
      diag_level        <= next_diag_level;
      last_out          <= next_last_out;
      status            <= next_status;
      reg_rdata_out     <= next_rdata;
    end
  end

endmodule

/* htc_defs.svh */
// Purpose: Offsets, field positions, reset values and scaling constants of the compensation stage
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   Definitions only
`ifndef HTC_DEFS_SVH
`define HTC_DEFS_SVH

`define HTC_ADDR_LIN_HOT     8'h00
`define HTC_ADDR_LIN_COLD    8'h04
`define HTC_ADDR_QUAD_HOT    8'h08
`define HTC_ADDR_QUAD_COLD   8'h0c
`define HTC_ADDR_OFFSET_COEF 8'h10
`define HTC_ADDR_UPPER       8'h14
`define HTC_ADDR_LOWER       8'h18
`define HTC_ADDR_CONTROL     8'h1c
`define HTC_ADDR_DIAG_LEVEL  8'h20
`define HTC_ADDR_LAST_OUT    8'h24
`define HTC_ADDR_STATUS      8'h28

`define HTC_CTRL_DIAG_BIT    0
`define HTC_STAT_HIGH_BIT    0
`define HTC_STAT_LOW_BIT     1
`define HTC_STAT_HOT_BIT     2

`define HTC_RST_LIN          8'h40
`define HTC_RST_QUAD         9'h000
`define HTC_RST_OFFSET       8'h00
`define HTC_RST_UPPER        11'h7ff
`define HTC_RST_LOWER        11'h000
`define HTC_RST_DIAG_LEVEL   16'h0000

`define HTC_REF_TEMP_C       10'sh019
`define HTC_LIN_BIAS         9'sh040
`define HTC_LIN_SHIFT        8
`define HTC_GAIN_SHIFT       24
`define HTC_CLP_STEP_Q8      32'h00000fa9
`define HTC_CLP_FRAC_SHIFT   8
`define HTC_CLP_HIGH_BASE    16'h828f
`define HTC_CLP_CODE_MAX     11'h7ff
`define HTC_FULL_SCALE       16'hffff

`endif

/* htc_pkg.sv */
// Purpose: Types shared by the compensation stage, its port checks and its bench
// Assumes: 16-bit output code where 16'hffff is full-scale output
// Notes:   Numbers live in htc_defs.svh
package htc_pkg;

  typedef struct packed {
    logic [7:0] lin;
    logic [8:0] quad;
  } htc_coef_set_type;

  typedef struct packed {
    logic        diag;
    logic [15:0] value;
  } htc_result_type;

endpackage

/* htc_pair_buffer.sv */
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock, asynchronous active-high reset
// Notes:   Head entry and both handshake outputs come straight from flops
`timescale 1ns/1ns
module htc_pair_buffer #(
  parameter int WIDTH = 17
) (
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least one");
  end

  logic [1:0]       count;
  logic [1:0]       next_count;
  logic [WIDTH-1:0] slot1;
  logic [WIDTH-1:0] next_slot0;
  logic [WIDTH-1:0] next_slot1;
  logic             push;
  logic             pop;

  always_comb begin
    push       = in_valid_in && in_ready_out;
    pop        = out_valid_out && out_ready_in;
    next_count = count;
    next_slot0 = out_data_out;
    next_slot1 = slot1;
    if (push && pop) begin
      if (count == 2'd1) begin
        next_slot0 = in_data_in;
      end else begin
        next_slot0 = slot1;
        next_slot1 = in_data_in;
      end
    end else if (pop) begin
      next_slot0 = slot1;
      next_count = count - 2'd1;
    end else if (push) begin
      if (count == 2'd0) begin
        next_slot0 = in_data_in;
      end else begin
        next_slot1 = in_data_in;
      end
      next_count = count + 2'd1;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count         <= 2'd0;
      out_data_out  <= '0;
      slot1         <= '0;
      out_valid_out <= 1'b0;
      in_ready_out  <= 1'b0;
    end else begin
      count         <= next_count;
      out_data_out  <= next_slot0;
      slot1         <= next_slot1;
      out_valid_out <= (next_count != 2'd0);
      in_ready_out  <= (next_count != 2'd2);
    end
  end

endmodule

/* htc_comp_clamp_asserts.sv */
// Purpose: Port-level checks of the compensation and clamp stage
// Assumes: Register writes mirrored here; limits stay still while results wait
// Notes:   Bound from the bench top file
`timescale 1ns/1ns
`include "htc_defs.svh"
module htc_comp_clamp_asserts
  import htc_pkg::*;
(
  input logic                 core_clk_in,
  input logic                 sys_rst_in,
  input logic           [7:0] reg_addr_in,
  input logic          [31:0] reg_wdata_in,
  input logic                 reg_write_in,
  input logic                 reg_read_in,
  input logic          [31:0] reg_rdata_out,
  input logic signed    [8:0] ambient_temp_in,
  input logic                 converter_valid_in,
  input logic                 converter_ready_out,
  input logic          [15:0] converter_sample_in,
  input logic                 compensated_valid_out,
  input logic                 compensated_ready_in,
  input htc_result_type       compensated_sample_out
);
  localparam logic [31:0] MASK [0:8] = '{32'hff, 32'hff, 32'h1ff, 32'h1ff, 32'hff,
                                         32'h7ff, 32'h7ff, 32'h1, 32'hffff};
  localparam logic [31:0] INIT [0:8] = '{32'h40, 32'h40, 0, 0, 0, 32'h7ff, 0, 0, 0};
  logic [31:0] shadow [0:8];
  logic [15:0] up_lim, lo_lim;
  logic [3:0]  idx;
  logic        mapped, live;
  assign idx = reg_addr_in[5:2];
  assign mapped = (reg_addr_in <= `HTC_ADDR_DIAG_LEVEL) && (reg_addr_in[1:0] == 2'b00);
  assign lo_lim = 16'((shadow[6] * `HTC_CLP_STEP_Q8) >> `HTC_CLP_FRAC_SHIFT);
  assign up_lim = (shadow[5] == 32'h7ff) ? 16'hffff :
                  `HTC_CLP_HIGH_BASE + 16'((shadow[5] * `HTC_CLP_STEP_Q8) >> `HTC_CLP_FRAC_SHIFT);
  // Mirror only; reset live flag hides the first edge after release
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shadow <= INIT;
      live <= 1'b0;
    end else begin
      live <= 1'b1;
      if (reg_write_in && mapped) shadow[idx] <= reg_wdata_in & MASK[idx];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_take; converter_valid_in && converter_ready_out; endsequence
  sequence s_stall; compensated_valid_out && !compensated_ready_in; endsequence
  AST_TAKE_TO_OUT: assert property (s_take ##0 !compensated_valid_out |=> compensated_valid_out)
    else $error("accepted sample did not reach the output");
  AST_STALL_HOLD: assert property (s_stall |=> compensated_valid_out && $stable(compensated_sample_out))
    else $error("output changed during receiver stall");
  AST_FULL_HEAD: assert property (live && !converter_ready_out |-> compensated_valid_out)
    else $error("input refused with empty output");
  AST_UPPER_CLAMP: assert property (compensated_valid_out && !compensated_sample_out.diag |-> compensated_sample_out.value <= up_lim)
    else $error("result above upper limit");
  AST_LOWER_CLAMP: assert property (compensated_valid_out && !compensated_sample_out.diag |-> compensated_sample_out.value >= lo_lim)
    else $error("result below lower limit");
  AST_DIAG_LEVEL: assert property (compensated_valid_out && compensated_sample_out.diag |-> compensated_sample_out.value == shadow[8][15:0])
    else $error("diagnostic level altered");
  AST_COEF_READ: assert property (reg_read_in && mapped && idx < 4'd5 |=> reg_rdata_out == $past(shadow[idx]))
    else $error("coefficient read back wrong");
  AST_CLAMP_READ: assert property (reg_read_in && (idx == 4'd5 || idx == 4'd6) && mapped |=> reg_rdata_out == $past(shadow[idx]))
    else $error("limit code read back wrong");
endmodule

/* htc_adc_model.sv */
// Purpose: Converter side model offering queued samples with random gaps
// Assumes: Bench pushes {temp, sample} words into pend
// Notes:   Idle data lines toggle so a stale value is never trusted
`timescale 1ns/1ns
module htc_adc_model (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ready_in,
  output logic             valid_out,
  output logic      [15:0] sample_out,
  output logic signed [8:0] temp_out
);
  logic [24:0] pend [$];
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      valid_out <= 1'b0;
      sample_out <= 16'h5a5a;
      temp_out <= 9'sh000;
    end else if (!valid_out || ready_in) begin
      if (pend.size() > 0 && $urandom_range(2) != 0) begin
        {temp_out, sample_out} <= pend.pop_front();
        valid_out <= 1'b1;
      end else begin
        valid_out <= 1'b0;
        sample_out <= ~sample_out;
        temp_out <= ~temp_out;
      end
    end
  end
endmodule

/* hall_temp_comp_clamp_path_tb_top.sv */
// Purpose: Self-checking bench of the compensation and clamp stage
// Assumes: Expected result noted when a sample is queued
// Notes:   Register changes only while no result is in flight
`timescale 1ns/1ns
`include "htc_defs.svh"
module hall_temp_comp_clamp_path_tb_top;
  import htc_pkg::*;
  localparam logic [31:0] MASK [0:8] = '{32'hff, 32'hff, 32'h1ff, 32'h1ff, 32'hff,
                                         32'h7ff, 32'h7ff, 32'h1, 32'hffff};
  localparam logic [31:0] INIT [0:8] = '{32'h40, 32'h40, 0, 0, 0, 32'h7ff, 0, 0, 0};
  localparam logic signed [8:0] TEMPS [0:5] = '{-9'sd40, 9'sd0, 9'sd24, 9'sd25, 9'sd26, 9'sd150};
  logic               core_clk_in, sys_rst_in, reg_write_in, reg_read_in, stall;
  logic         [7:0] reg_addr_in;
  logic        [31:0] reg_wdata_in, reg_rdata_out;
  logic               conv_valid, conv_ready, comp_valid, comp_ready;
  logic        [15:0] conv_sample;
  logic signed  [8:0] conv_temp;
  htc_result_type     comp_out;
  logic        [31:0] regs [0:8];
  logic        [16:0] expq [$];
  int                 miscompares, samples_checked, cycles;
  htc_comp_clamp #(.INITIAL_GAIN(21), .OFFSET_SHIFT(8)) htc_comp_clamp_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .ambient_temp_in(conv_temp),
    .converter_valid_in(conv_valid), .converter_ready_out(conv_ready),
    .converter_sample_in(conv_sample), .compensated_valid_out(comp_valid),
    .compensated_ready_in(comp_ready), .compensated_sample_out(comp_out));
  htc_adc_model htc_adc_model_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .ready_in(conv_ready), .valid_out(conv_valid), .sample_out(conv_sample),
    .temp_out(conv_temp));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    if (a <= 8'h20 && a[1:0] == 2'b00) regs[a[5:2]] = d & MASK[a[5:2]];
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  // Signed arithmetic except the unsigned limit lines; a 16-bit unsigned operand would turn it unsigned
  function automatic logic [16:0] expv(logic [15:0] s, logic signed [8:0] t);
    longint d, sl, ln, q, tot, up, lo;
    d = t - 25;
    sl = s;
    ln = longint'((d > 0) ? regs[0] : regs[1]) - 64;
    q = (d > 0) ? longint'($signed(regs[2][8:0])) : longint'($signed(regs[3][8:0]));
    tot = sl + (((ln * d * 256 + q * d * d) * sl) >>> 24);
    tot = tot + ((longint'($signed(regs[4][7:0])) * d * 21) >>> 8);
    lo = (regs[6] * 4009) >> 8;
    up = (regs[5] == 32'h7ff) ? 65535 : 33423 + ((regs[5] * 4009) >> 8);
    if (regs[7][0]) return {1'b1, regs[8][15:0]};
    if (tot > up) tot = up;
    else if (tot < lo) tot = lo;
    return {1'b0, 16'(tot)};
  endfunction
  task automatic send(logic [15:0] s, logic signed [8:0] t);
    htc_adc_model_inst.pend.push_back({t, s});
    expq.push_back(expv(s, t));
  endtask
  task automatic drain();
    for (int n = 0; n < 400 && expq.size() > 0; n++) @(posedge core_clk_in);
    chk(expq.size(), 0);
    $display("Test step done at %0t", $time);
  endtask
  always @(posedge core_clk_in) begin
    comp_ready <= !stall && ($urandom_range(3) != 0);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
    if (!sys_rst_in && comp_valid && comp_ready)
      chk(comp_out, (expq.size() > 0) ? expq.pop_front() : 32'hxxxxxxxx);
  end
  initial begin
    sys_rst_in = 1'b1;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    comp_ready = 1'b0;
    stall = 1'b0;
    regs = INIT;
    void'($urandom(41));
    repeat (16) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 12; i++) rd(8'(i * 4), (i < 9) ? INIT[i] : 32'h0);
    $display("Test reset values done");
    for (int i = 0; i < 5; i++) wr(8'(i * 4), $urandom);
    for (int i = 0; i < 5; i++) rd(8'(i * 4), regs[i]);
    foreach (TEMPS[i]) send(16'($urandom), TEMPS[i]);
    repeat (40) send(16'($urandom), 9'($urandom_range(190)) - 9'sd40);
    drain();
    for (int i = 0; i < 3; i++) begin
      wr(`HTC_ADDR_UPPER, (i == 0) ? 32'h0 : $urandom);
      wr(`HTC_ADDR_LOWER, (i == 0) ? 32'h7ff : $urandom);
      rd(`HTC_ADDR_UPPER, regs[5]);
      send(16'hffff, 9'sd25);
      send(16'h0000, -9'sd40);
      repeat (6) send(16'($urandom), 9'($urandom_range(190)) - 9'sd40);
      drain();
    end
    wr(`HTC_ADDR_UPPER, 32'h0);
    wr(`HTC_ADDR_LOWER, 32'h7ff);
    send(16'hffff, 9'sd25);
    drain();
    rd(`HTC_ADDR_STATUS, 32'h1);
    rd(`HTC_ADDR_LAST_OUT, 32'h828f);
    send(16'h0000, 9'sd26);
    drain();
    rd(`HTC_ADDR_STATUS, 32'h6);
    rd(`HTC_ADDR_LAST_OUT, 32'h7d38);
    stall <= 1'b1;
    repeat (6) send(16'($urandom), 9'($urandom_range(190)) - 9'sd40);
    for (int n = 0; n < 60 && conv_ready !== 1'b0; n++) @(posedge core_clk_in);
    #1 chk(conv_ready, 32'h0);
    chk(comp_valid, 32'h1);
    stall <= 1'b0;
    drain();
    wr(`HTC_ADDR_DIAG_LEVEL, $urandom);
    wr(`HTC_ADDR_CONTROL, 32'h1);
    repeat (4) send(16'($urandom), 9'sd130);
    drain();
    wr(`HTC_ADDR_CONTROL, 32'h0);
    end_of_test();
  end
endmodule
bind htc_comp_clamp htc_comp_clamp_asserts htc_comp_clamp_asserts_inst (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out), .ambient_temp_in(ambient_temp_in),
  .converter_valid_in(converter_valid_in), .converter_ready_out(converter_ready_out),
  .converter_sample_in(converter_sample_in), .compensated_valid_out(compensated_valid_out),
  .compensated_ready_in(compensated_ready_in), .compensated_sample_out(compensated_sample_out));
